/* File: common/frm_pkg.sv */
// Shared constants and types for the fault response manager
package frm_pkg;

	// Clock rate and millisecond base
	localparam int unsigned CLK_HZ       = 25_000_000;
	localparam int unsigned MS_PER_S     = 1000;
	localparam int unsigned MS_CYCLES    = CLK_HZ / MS_PER_S;
	// Longest allowed report and clear latency, in ms
	localparam int unsigned REPORT_MAX_MS = 200;

	// Register byte addresses
	localparam int unsigned  ADDR_W      = 8;
	localparam logic [7:0]   ADDR_CTRL   = 8'h00;
	localparam logic [7:0]   ADDR_STATUS = 8'h04;
	localparam logic [2:0]   HSIZE_WORD  = 3'h2;

	// Control register fields
	localparam int unsigned  CTRL_W          = 18;
	localparam int unsigned  CTRL_FCLR_BIT   = 0;
	localparam int unsigned  CTRL_RCLR_BIT   = 1;
	localparam int unsigned  CTRL_ALERT_BIT  = 2;
	localparam int unsigned  CTRL_OVP_BIT    = 3;
	localparam int unsigned  CTRL_OCP_LSB    = 4;
	localparam int unsigned  CTRL_LIM_LSB    = 6;
	localparam int unsigned  CTRL_REGACT_BIT = 9;
	localparam int unsigned  CTRL_INTV_LSB   = 10;
	localparam logic [17:0]  CTRL_RESET      = 18'h0C80C;
	localparam logic [17:0]  CTRL_STORE_MASK = 18'h3FFFC;

	// Status register fields
	localparam int unsigned  ST_FLAG_LSB  = 0;
	localparam int unsigned  ST_STATE_LSB = 3;
	localparam int unsigned  ST_LIMIT_BIT = 5;
	localparam int unsigned  ST_CNT_LSB   = 6;
	localparam int unsigned  ST_STAGE_BIT = 9;
	localparam int unsigned  ST_CORE_BIT  = 10;

	// Overcurrent response codes
	localparam logic [1:0]   OCP_LATCH = 2'h0;
	localparam logic [1:0]   OCP_RETRY = 2'h1;
	// Retry interval of the self-recovering faults, in ms
	localparam logic [7:0]   AUTO_RETRY_MS = 8'h05;

	// Fault condition inputs, one bit each
	localparam int unsigned  F_SUPPLY = 0;
	localparam int unsigned  F_RAIL   = 1;
	localparam int unsigned  F_REG    = 2;
	localparam int unsigned  F_PUMP   = 3;
	localparam int unsigned  F_OVP    = 4;
	localparam int unsigned  F_OC     = 5;
	localparam int unsigned  F_REPORT = 6;
	localparam int unsigned  NUM_F    = 7;

	// Recovery state
	typedef enum logic [1:0] {
		ST_RUN,
		ST_RETRY,
		ST_LATCH
	} frm_state_e;

endpackage : frm_pkg

/* File: rtl/frm_sync.sv */
// Two-stage synchroniser for asynchronous fault condition inputs
module frm_sync
	import frm_pkg::*;
#(
	parameter int unsigned W = NUM_F
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	// Raw and synchronised conditions
	input  wire logic [W-1:0] raw,
	output logic      [W-1:0] sync
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
	} frm_sync_s;

	frm_sync_s s_q;
	frm_sync_s s_d;

	// First stage feeds only the second
	always_comb begin
		s_d      = s_q;
		s_d.meta = raw;
		s_d.stab = s_q.meta;
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync = s_q.stab;

endmodule : frm_sync

/* File: rtl/frm_tick.sv */
// Divider that emits a one-cycle pulse every DIV clocks
module frm_tick
	import frm_pkg::*;
#(
	parameter int unsigned DIV = MS_CYCLES
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Enable pulse
	output logic      tick
);

	localparam int unsigned CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          pulse;
	} frm_tick_s;

	frm_tick_s s_q;
	frm_tick_s s_d;

	// Count up one period, pulse on wrap
	always_comb begin
		s_d       = s_q;
		s_d.pulse = (s_q.cnt == LAST);
		s_d.cnt   = s_d.pulse ? '0 : s_q.cnt + 1'b1;
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.pulse;

endmodule : frm_tick

/* File: rtl/frm_top.sv */
// Fault supervision, priority and recovery with an AHB-Lite register slave
//
// Added by the designer: the register offsets and the AHB-Lite register port.

////////////////////////////////////////////////////////////////////////////////
module frm_top
	import frm_pkg::*;
#(
	parameter int unsigned MS_DIV = MS_CYCLES
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Fault condition inputs from comparators
	input  wire logic        supply_low,
	input  wire logic        rail_low,
	input  wire logic        regulator_low_fault,
	input  wire logic        pump_low_fault,
	input  wire logic        supply_over,
	input  wire logic        phase_overcurrent,
	input  wire logic        report_only_fault,
	// Fault pins and power control
	output logic             fault_n_pin,
	output logic             alert_output_pin,
	output logic             stage_enable,
	output logic             core_enable
);

	typedef struct packed {
		frm_state_e        st;
		logic              lim_lat;
		logic [7:0]        tmr;
		logic [7:0]        tgt;
		logic [2:0]        cnt;
		logic [2:0]        flags;
		logic [CTRL_W-1:0] ctrl;
		logic              clr_cmd;
		logic              cnt_clr_cmd;
		logic [ADDR_W-1:0] a_addr;
		logic              a_hit;
		logic              a_wr;
		logic              a_pend;
		logic              rdy;
		logic [31:0]       rdata;
		logic              fault_n;
		logic              alert;
		logic              stage;
		logic              core;
	} frm_regs_s;

	frm_regs_s s_q;
	frm_regs_s s_d;

	logic [NUM_F-1:0] f;
	logic             ms_tick;

	////////////////////////////////////////////////////////////////////////////
	// Input synchroniser and millisecond base
	frm_sync #(.W(NUM_F)) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.raw      ({report_only_fault, phase_overcurrent, supply_over,
		            pump_low_fault, regulator_low_fault, rail_low, supply_low}),
		.sync     (f)
	);

	frm_tick #(.DIV(MS_DIV)) u_tick (
		.core_clk (core_clk),
		.rst      (rst),
		.tick     (ms_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Configuration fields
	logic       alert_output_enable;
	logic       overvoltage_guard_enable;
	logic [1:0] overcurrent_response_select;
	logic [2:0] retry_limit_setting;
	logic       regulator_shutdown;
	logic [7:0] retry_interval;

	assign alert_output_enable         = s_q.ctrl[CTRL_ALERT_BIT];
	assign overvoltage_guard_enable    = s_q.ctrl[CTRL_OVP_BIT];
	assign overcurrent_response_select = s_q.ctrl[CTRL_OCP_LSB +: 2];
	assign retry_limit_setting         = s_q.ctrl[CTRL_LIM_LSB +: 3];
	assign regulator_shutdown          = s_q.ctrl[CTRL_REGACT_BIT];
	assign retry_interval              = s_q.ctrl[CTRL_INTV_LSB +: 8];

	////////////////////////////////////////////////////////////////////////////
	// Fault classification
	logic       ovp_act;
	logic       oc_latch;
	logic       oc_retry;
	logic       auto_f;
	logic       retry_any;
	logic [7:0] need;

	always_comb begin
		ovp_act   = f[F_OVP] & overvoltage_guard_enable;
		oc_latch  = f[F_OC] & (overcurrent_response_select == OCP_LATCH);
		oc_retry  = f[F_OC] & (overcurrent_response_select != OCP_LATCH);
		auto_f    = f[F_PUMP] | ovp_act;
		retry_any = auto_f | oc_retry;
		// Longest interval among the retry faults now present
		need = '0;
		if (auto_f) begin
			need = AUTO_RETRY_MS;
		end
		if (oc_retry && (retry_interval > need)) begin
			need = retry_interval;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic: bus slave, recovery machine, outputs
	logic [2:0] cnt_inc;
	logic       actionable;

	always_comb begin
		s_d             = s_q;
		s_d.clr_cmd     = 1'b0;
		s_d.cnt_clr_cmd = 1'b0;
		cnt_inc         = s_q.cnt + 3'h1;

		// Bus: one wait state, then registered answer
		if (s_q.a_pend) begin
			s_d.a_pend = 1'b0;
			s_d.rdy    = 1'b1;
			s_d.rdata  = '0;
			if (s_q.a_wr) begin
				if (s_q.a_hit && (s_q.a_addr == ADDR_CTRL)) begin
					s_d.ctrl        = hwdata[CTRL_W-1:0] & CTRL_STORE_MASK;
					s_d.clr_cmd     = hwdata[CTRL_FCLR_BIT];
					s_d.cnt_clr_cmd = hwdata[CTRL_RCLR_BIT];
				end
			end else if (s_q.a_hit && (s_q.a_addr == ADDR_CTRL)) begin
				s_d.rdata[CTRL_W-1:0] = s_q.ctrl;
			end else if (s_q.a_hit && (s_q.a_addr == ADDR_STATUS)) begin
				s_d.rdata[ST_FLAG_LSB +: 3]  = s_q.flags;
				s_d.rdata[ST_STATE_LSB +: 2] = s_q.st;
				s_d.rdata[ST_LIMIT_BIT]      = s_q.lim_lat;
				s_d.rdata[ST_CNT_LSB +: 3]   = s_q.cnt;
				s_d.rdata[ST_STAGE_BIT]      = s_q.stage;
				s_d.rdata[ST_CORE_BIT]       = s_q.core;
			end
		end else if (hsel && htrans[1] && hready && (hsize == HSIZE_WORD)) begin
			s_d.a_pend = 1'b1;
			s_d.rdy    = 1'b0;
			s_d.a_addr = haddr[ADDR_W-1:0];
			s_d.a_hit  = (haddr[31:ADDR_W] == '0);
			s_d.a_wr   = hwrite;
		end

		// Sticky gate-stage flags; a new fault wins over a clear
		s_d.flags = (s_q.clr_cmd ? 3'h0 : s_q.flags) | {f[F_OC], ovp_act, f[F_PUMP]};

		// Retry counter clear command
		if (s_q.cnt_clr_cmd) begin
			s_d.cnt = '0;
		end

		// Recovery machine; latched entry outranks any retry
		unique case (s_q.st)
			ST_RUN: begin
				if (oc_latch) begin
					s_d.st = ST_LATCH;
				end else if (retry_any) begin
					s_d.st  = ST_RETRY;
					s_d.tmr = '0;
					s_d.tgt = need;
				end
			end
			ST_RETRY: begin
				if (oc_latch) begin
					s_d.st = ST_LATCH;
				end else if (retry_any) begin
					s_d.tmr = '0;
					if (need > s_q.tgt) begin
						s_d.tgt = need;
					end
				end else if (s_q.tmr >= s_q.tgt) begin
					s_d.st = ST_RUN;
					if (s_q.cnt != 3'h7) begin
						s_d.cnt = cnt_inc;
					end
				end else if (ms_tick) begin
					s_d.tmr = s_q.tmr + 8'h01;
				end
			end
			ST_LATCH: begin
				if (s_q.clr_cmd && (!s_q.lim_lat || s_q.cnt_clr_cmd)) begin
					s_d.lim_lat = 1'b0;
					// A retry fault or latching overcurrent still present at the clear keeps the pins asserted
					if (retry_any && !oc_latch) begin
						s_d.st  = ST_RETRY;
						s_d.tmr = '0;
						s_d.tgt = need;
					end else if (!oc_latch) begin
						s_d.st = ST_RUN;
					end
				end
			end
		endcase

		// Reaching the cumulative limit forces the latched state
		if ((retry_limit_setting != 3'h0) && (s_d.cnt >= retry_limit_setting)) begin
			s_d.st      = ST_LATCH;
			s_d.lim_lat = 1'b1;
		end

		// Pins and stage enable follow the next state; core enable follows the undervoltage inputs
		actionable  = (s_d.st != ST_RUN);
		s_d.fault_n = !(actionable || (f[F_REPORT] && !alert_output_enable));
		s_d.alert   = alert_output_enable && (actionable || f[F_REPORT]);
		s_d.core    = !(f[F_SUPPLY] || f[F_RAIL] || (f[F_REG] && regulator_shutdown));
		s_d.stage   = s_d.core && !actionable;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_q         <= '0;
			s_q.st      <= ST_RUN;
			s_q.ctrl    <= CTRL_RESET;
			s_q.rdy     <= 1'b1;
			s_q.fault_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops, except hresp which is tied low
	assign hreadyout        = s_q.rdy;
	assign hresp            = 1'b0;
	assign hrdata           = s_q.rdata;
	assign fault_n_pin      = s_q.fault_n;
	assign alert_output_pin = s_q.alert;
	assign stage_enable     = s_q.stage;
	assign core_enable      = s_q.core;

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_fault_pin_low;
		(s_q.st != ST_RUN) |-> !fault_n_pin;
	endproperty
	a_fault_pin_low: assert property (p_fault_pin_low)
		else $error("actionable fault not on fault pin");

	property p_alert_high;
		(s_q.st != ST_RUN) && $past(alert_output_enable) |-> alert_output_pin;
	endproperty
	a_alert_high: assert property (p_alert_high)
		else $error("actionable fault not on alert pin");

	property p_report_only_alert;
		(s_q.st == ST_RUN) && (s_d.st == ST_RUN) && f[F_REPORT] && alert_output_enable
			|=> fault_n_pin && alert_output_pin;
	endproperty
	a_report_only_alert: assert property (p_report_only_alert)
		else $error("report-only fault pulled fault pin with alert enabled");

	property p_latch_holds;
		(s_q.st == ST_LATCH) && !s_q.clr_cmd |=> (s_q.st == ST_LATCH) && !stage_enable;
	endproperty
	a_latch_holds: assert property (p_latch_holds)
		else $error("latched state left without clear");

	property p_clear_exits;
		(s_q.st == ST_LATCH) && s_q.clr_cmd && !s_q.lim_lat && !f[F_OC] && !retry_any
			|=> (s_q.st == ST_RUN);
	endproperty
	a_clear_exits: assert property (p_clear_exits)
		else $error("latched fault not cleared");

	property p_longest_wait;
		(s_q.st == ST_RETRY) && oc_retry && !oc_latch |=> (s_q.tgt >= $past(retry_interval));
	endproperty
	a_longest_wait: assert property (p_longest_wait)
		else $error("retry target below the longer interval");

	property p_exit_after_interval;
		(s_q.st == ST_RETRY) ##1 (s_q.st == ST_RUN) |-> ($past(s_q.tmr) >= $past(s_q.tgt));
	endproperty
	a_exit_after_interval: assert property (p_exit_after_interval)
		else $error("retry ended before its interval");

	property p_timer_held;
		(s_q.st == ST_RETRY) && retry_any && !oc_latch |=> (s_q.tmr == 8'h00);
	endproperty
	a_timer_held: assert property (p_timer_held)
		else $error("retry timer ran while condition present");

	property p_limit_latch;
		(retry_limit_setting != 3'h0) && (s_q.cnt >= retry_limit_setting) && !s_q.cnt_clr_cmd
			|=> (s_q.st == ST_LATCH);
	endproperty
	a_limit_latch: assert property (p_limit_latch)
		else $error("retry limit reached without latch");

	property p_supply_off;
		f[F_SUPPLY] || f[F_RAIL] |=> !stage_enable && !core_enable;
	endproperty
	a_supply_off: assert property (p_supply_off)
		else $error("undervoltage left stage or core on");

	property p_pump_report;
		f[F_PUMP] && !f[F_SUPPLY] && !f[F_RAIL] && !(f[F_REG] && regulator_shutdown)
			|=> !fault_n_pin && !stage_enable && core_enable;
	endproperty
	a_pump_report: assert property (p_pump_report)
		else $error("pump fault response wrong");

	property p_ovp_ignored;
		(s_q.st == ST_RUN) && f[F_OVP] && !overvoltage_guard_enable && !f[F_PUMP] && !f[F_OC]
			&& !f[F_REPORT] && !s_q.a_pend |=> fault_n_pin;
	endproperty
	a_ovp_ignored: assert property (p_ovp_ignored)
		else $error("overvoltage acted while guard off");

	property p_clear_one_shot;
		s_q.clr_cmd |=> !s_q.clr_cmd;
	endproperty
	a_clear_one_shot: assert property (p_clear_one_shot)
		else $error("clear command held beyond one cycle");

	c_retry_recover: cover property ((s_q.st == ST_RETRY) ##1 (s_q.st == ST_RUN));
	c_latch_clear:   cover property ((s_q.st == ST_LATCH) ##1 (s_q.st == ST_RUN));
	c_limit_latch:   cover property (s_q.lim_lat && (s_q.st == ST_LATCH));
	c_bus_read:      cover property (s_q.a_pend && !s_q.a_wr);

endmodule : frm_top

/* File: tb/frm_sense.sv */
// Comparator front end that raises the fault condition lines
module frm_sense
	import frm_pkg::*;
(
	// Clock
	input  wire logic             core_clk,
	// Conditions asked for by the bench
	input  wire logic [NUM_F-1:0] cond,
	// Condition lines towards the core
	output logic                  supply_low,
	output logic                  rail_low,
	output logic                  regulator_low_fault,
	output logic                  pump_low_fault,
	output logic                  supply_over,
	output logic                  phase_overcurrent,
	output logic                  report_only_fault
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [NUM_F-1:0] line_q = '0;

	// Lines move on the edge itself, through a nonblocking update with no delay
	always @(posedge core_clk) line_q <= cond;

	// One comparator for each line
	assign supply_low          = line_q[F_SUPPLY];
	assign rail_low            = line_q[F_RAIL];
	assign regulator_low_fault = line_q[F_REG];
	assign pump_low_fault      = line_q[F_PUMP];
	assign supply_over         = line_q[F_OVP];
	assign phase_overcurrent   = line_q[F_OC];
	assign report_only_fault   = line_q[F_REPORT];
endmodule : frm_sense

/* File: tb/test_fault_response_manager.sv */
// Self-checking testbench for the fault response manager
module test_fault_response_manager
	import frm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic             core_clk = 1'b0;
	logic             rst = 1'b1;
	logic             hsel = 1'b0;
	logic      [31:0] haddr = '0;
	logic      [1:0]  htrans = '0;
	logic             hwrite = 1'b0;
	logic      [2:0]  hsize = HSIZE_WORD;
	logic      [31:0] hwdata = '0;
	logic             hreadyout;
	logic             hresp;
	logic      [31:0] hrdata;
	logic [NUM_F-1:0] cond = '0;
	logic             sup_l, rail_l, reg_l, pump_l, ovr_l, oc_l, rep_l;
	logic             fault_n_pin, alert_output_pin, stage_enable, core_enable;
	logic             pchk = 1'b0;
	logic             rd_pend = 1'b0;
	logic      [31:0] rq[$], rmq[$];
	logic      [3:0]  pq[$], pmq[$];
	int               errors = 0;
	int               checked = 0;

	frm_sense frm_sense_i (.core_clk(core_clk), .cond(cond),
		.supply_low(sup_l), .rail_low(rail_l), .regulator_low_fault(reg_l),
		.pump_low_fault(pump_l), .supply_over(ovr_l), .phase_overcurrent(oc_l),
		.report_only_fault(rep_l));

	frm_top #(.MS_DIV(10)) frm_top_i (.core_clk(core_clk), .rst(rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.supply_low(sup_l), .rail_low(rail_l), .regulator_low_fault(reg_l),
		.pump_low_fault(pump_l), .supply_over(ovr_l), .phase_overcurrent(oc_l),
		.report_only_fault(rep_l), .fault_n_pin(fault_n_pin),
		.alert_output_pin(alert_output_pin), .stage_enable(stage_enable),
		.core_enable(core_enable));

	// 25 MHz clock
	initial forever #20 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////
	task automatic cmp_rd(input logic [31:0] e, s, m);
		checked++;
		if ((s & m) !== (e & m)) begin
			errors++;
			$display("wrong value hrdata expected %h seen %h", e & m, s & m);
		end
	endtask : cmp_rd

	task automatic cmp_pin(input logic [3:0] e, s, m);
		checked++;
		if ((s & m) !== (e & m)) begin
			errors++;
			$display("wrong value pins expected %b seen %b", e & m, s & m);
		end
	endtask : cmp_pin

	task automatic stop_test;
		if (errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	// Wait for hready high at a rising edge; only the watchdog ends a hang
	task automatic rdy;
		do begin
			@(negedge core_clk);
		end while (hreadyout !== 1'b1);
		@(posedge core_clk);
	endtask : rdy

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, e, m);
		if (!w) begin
			rq.push_back(e);
			rmq.push_back(m);
		end
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, '0, '0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		xfer(1'b0, a, '0, e, m);
	endtask : rd

	// Pin vector is {fault_n, alert, stage, core}
	task automatic pin(input logic [3:0] e, input logic [3:0] m = 4'hF);
		pq.push_back(e);
		pmq.push_back(m);
		pchk <= 1'b1;
		@(posedge core_clk);
		pchk <= 1'b0;
	endtask : pin

	// Match each result seen at the outputs with the oldest note
	always @(posedge core_clk) begin
		if (rd_pend && hreadyout === 1'b1) begin
			rd_pend <= 1'b0;
			cmp_rd(rq.pop_front(), hrdata, rmq.pop_front());
			cmp_rd(32'h0, {31'h0, hresp}, 32'h1);
		end
		if (hsel && htrans[1] && hreadyout && !hwrite)
			rd_pend <= 1'b1;
		if (pchk)
			cmp_pin(pq.pop_front(), {fault_n_pin, alert_output_pin, stage_enable,
				core_enable}, pmq.pop_front());
	end

	// Watchdog against a hang
	initial begin
		cyc(20000);
		errors++;
		stop_test();
	end

	////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(42215));
		cyc(16);
		rst <= 1'b0;
		cyc(4);
		pin(4'hB);
		rd(ADDR_CTRL, 32'h0C80C, '1);
		wr(ADDR_STATUS, '1);
		rd(ADDR_STATUS, 32'h600, 32'h7FF);
		rd(8'($urandom_range(2, 60) << 2), '0, '1);
		wr(ADDR_CTRL, 32'hC0F);
		rd(ADDR_CTRL, 32'hC0C, '1);
		// Supply and rail lockout: all off, nothing reported
		for (int i = 0; i < 2; i++) begin
			cond[i] <= 1'b1;
			cyc(6);
			pin(4'h8);
			cond[i] <= 1'b0;
			cyc(6);
			pin(4'hB);
		end
		// Regulator low acts only when its shutdown is enabled
		cond[F_REG] <= 1'b1;
		cyc(6);
		pin(4'hB);
		wr(ADDR_CTRL, 32'hE0C);
		cyc(4);
		pin(4'h8);
		cond[F_REG] <= 1'b0;
		cyc(6);
		pin(4'hB);
		wr(ADDR_CTRL, 32'hC0C);
		// Pump low: timer held while present, retry after release
		cond[F_PUMP] <= 1'b1;
		cyc(6);
		pin(4'h5);
		rd(ADDR_STATUS, 32'h1, 32'h1);
		cyc(100);
		cond[F_PUMP] <= 1'b0;
		cyc(20);
		pin(4'h0, 4'h2);
		cyc(60);
		pin(4'hB);
		// Report-only fault, alert on then off
		cond[F_REPORT] <= 1'b1;
		cyc(6);
		pin(4'hF);
		wr(ADDR_CTRL, 32'hC08);
		cyc(4);
		pin(4'h3);
		cond[F_REPORT] <= 1'b0;
		wr(ADDR_CTRL, 32'hC0C);
		// Overvoltage, guard off then on
		wr(ADDR_CTRL, 32'hC04);
		cond[F_OVP] <= 1'b1;
		cyc(6);
		pin(4'hB);
		wr(ADDR_CTRL, 32'hC0C);
		cyc(6);
		pin(4'h5);
		cond[F_OVP] <= 1'b0;
		cyc(80);
		pin(4'hB);
		// Latched overcurrent beside a retry fault
		cond[F_OC] <= 1'b1;
		cond[F_PUMP] <= 1'b1;
		cyc(6);
		pin(4'h5);
		rd(ADDR_STATUS, 32'h10, 32'h18);
		cyc($urandom_range(3, 9));
		cond[F_OC] <= 1'b0;
		cond[F_PUMP] <= 1'b0;
		cyc(150);
		pin(4'h5);
		wr(ADDR_CTRL, 32'hC0D);
		cyc(6);
		pin(4'hB);
		// Retrying overcurrent at 20 ms beside the 5 ms pump retry
		wr(ADDR_CTRL, 32'h500C | ($urandom_range(1, 3) << 4));
		cond[F_OC] <= 1'b1;
		cond[F_PUMP] <= 1'b1;
		cyc(6);
		pin(4'h5);
		rd(ADDR_STATUS, 32'h8, 32'h18);
		cond[F_OC] <= 1'b0;
		cond[F_PUMP] <= 1'b0;
		cyc(150);
		pin(4'h0, 4'h2);
		cyc(80);
		pin(4'hB);
		// Retry limit of two latches, needs both clear bits
		wr(ADDR_CTRL, 32'hC0F);
		wr(ADDR_CTRL, 32'hC8C);
		for (int i = 0; i < 2; i++) begin
			cond[F_PUMP] <= 1'b1;
			cyc(6);
			cond[F_PUMP] <= 1'b0;
			cyc(80);
		end
		pin(4'h5);
		rd(ADDR_STATUS, 32'hB0, 32'h1F8);
		wr(ADDR_CTRL, 32'hC8D);
		cyc(6);
		pin(4'h5);
		wr(ADDR_CTRL, 32'hC8F);
		cyc(6);
		pin(4'hB);
		rd(ADDR_STATUS, 32'h0, 32'h1F8);
		rd(ADDR_CTRL, 32'hC8C, '1);
		stop_test();
	end
endmodule : test_fault_response_manager
